/* File: rtl/hcd_pkg.sv */
// Purpose: Shared constants for the hall commutation decoder.
// Assumes: AHB-Lite word registers, byte addresses below.
// Notes:   Table entries sit at HCD_TBL_BASE plus four times the index.
package hcd_pkg;
  // Register byte addresses.
  localparam logic [7:0] HCD_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] HCD_SRCE_ADDR  = 8'h04;
  localparam logic [7:0] HCD_SPOS_ADDR  = 8'h08;
  localparam logic [7:0] HCD_FCTL_ADDR  = 8'h0c;
  localparam logic [7:0] HCD_CHK_ADDR   = 8'h10;
  localparam logic [7:0] HCD_STAT_ADDR  = 8'h14;
  localparam logic [7:0] HCD_IEN_ADDR   = 8'h18;
  localparam logic [7:0] HCD_ICLR_ADDR  = 8'h1c;
  localparam logic [7:0] HCD_TBL_BASE   = 8'h40;
  localparam int         HCD_TBL_N      = 12;
  localparam logic [3:0] HCD_BWD_OFS    = 4'h6;
  // Control register fields.
  localparam int HCD_EN_BIT    = 0;
  localparam int HCD_DIR_BIT   = 1;
  localparam int HCD_BRK_BIT   = 2;
  localparam int HCD_MODE_BIT  = 3;
  localparam int HCD_ANG_BIT   = 4;
  localparam int HCD_DLY_BIT   = 5;
  localparam int HCD_TSEL_LSB  = 6;
  // Source and edge register fields.
  localparam int HCD_SRC_BIT   = 6;
  // Filter control fields.
  localparam int HCD_FEN_BIT   = 3;
  // Reset values.
  localparam logic [7:0] HCD_CTRL_RST = 8'h10;
  localparam logic [5:0] HCD_BRAKE_PAT = 6'h15;
  // Edge select encodings.
  localparam logic [1:0] HCD_EDGE_OFF  = 2'h0;
  localparam logic [1:0] HCD_EDGE_RISE = 2'h1;
  localparam logic [1:0] HCD_EDGE_FALL = 2'h2;
  localparam logic [1:0] HCD_EDGE_BOTH = 2'h3;
  localparam logic [2:0] HCD_FCLK_NONE = 3'h7;
endpackage : hcd_pkg

/* File: rtl/hcd_filter.sv */
// Purpose: One channel of the position noise filter.
// Assumes: sample_en is a one-cycle pulse at the sampling rate.
// Notes:   A change passes once check_cnt further samples agree.
`timescale 1ns/1ps
`default_nettype none
module hcd_filter
  import hcd_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       filter_enable,
  input  wire logic       sample_en,
  input  wire logic [4:0] filter_check_count,
  // Data
  input  wire logic       raw_in,
  output logic            filt_out
);
  typedef struct packed {
    logic       level;
    logic [4:0] cnt;
  } hcd_flt_t;

  hcd_flt_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    if (!filter_enable)
    begin
      s_d.level = raw_in;
      s_d.cnt   = 5'h00;
    end
    else if (sample_en)
    begin
      if (raw_in == s_q.level)
        s_d.cnt = 5'h00;
      else if (s_q.cnt >= filter_check_count)
      begin
        s_d.level = raw_in;
        s_d.cnt   = 5'h00;
      end
      else
        s_d.cnt = s_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Bypass is combinational so a disabled filter adds no latency.
  assign filt_out = filter_enable ? s_q.level : raw_in;
endmodule : hcd_filter
`default_nettype wire

/* File: rtl/hcd_decoder.sv */
// Purpose: Hall commutation decoder with AHB-Lite registers.
// Assumes: Single clock hclk at 40 MHz, zero-wait slave.
// Notes:   Timers live outside; this block only steers and waits on them.
`timescale 1ns/1ps
`default_nettype none
module hcd_decoder
  import hcd_pkg::*;
(
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Position inputs
  input  wire logic [2:0]  sensor_pins,
  input  wire logic [2:0]  comparator_outputs,
  // Delay timers: match pulses in, run requests out
  input  wire logic [2:0]  delay_timer_match,
  output logic [2:0]       delay_timer_run,
  // Gate drive commands
  output logic             drive_a_top,
  output logic             drive_a_bottom,
  output logic             drive_b_top,
  output logic             drive_b_bottom,
  output logic             drive_c_top,
  output logic             drive_c_bottom,
  // Interrupts
  output logic             position_irq_a,
  output logic             position_irq_b,
  output logic             position_irq_c,
  output logic             irq
);
  typedef struct packed {
    logic            dph_wr;
    logic [7:0]      dph_addr;
    logic [31:0]     rdata;
    logic [7:0]      ctrl;
    logic [6:0]      srce;
    logic [2:0]      spos;
    logic [3:0]      fctl;
    logic [4:0]      chk;
    logic [11:0][5:0] tbl;
    logic [2:0]      stat;
    logic [2:0]      ien;
    logic [2:0]      pulse;
    logic [6:0]      div;
    logic [2:0]      prev;
    logic [2:0]      dly_in;
    logic [2:0]      dly_out;
    logic            dly_pend;
    logic [5:0]      drive;
  } hcd_state_t;

  hcd_state_t s_q, s_d;

  logic [2:0] raw_sel;
  logic [2:0] filt;
  logic [2:0] hw_code;
  logic [2:0] code;
  logic [2:0] edge_hit;
  logic [2:0] idx;
  logic       valid;
  logic [6:0] div_mask;
  logic       sample_en;
  logic       a_phase;
  logic [2:0] tsel_hot;

  // Comparators and pins are both bit 0 = phase A.
  assign raw_sel = s_q.srce[HCD_SRC_BIT] ? comparator_outputs
                                         : sensor_pins;

  // Sampling enable: hclk over 2 to the (sel+1); code 111 never samples.
  assign div_mask  = 7'((8'h02 << s_q.fctl[2:0]) - 8'h01);
  assign sample_en = (s_q.fctl[2:0] != HCD_FCLK_NONE)
                     && ((s_q.div & div_mask) == div_mask);

  for (genvar g = 0; g < 3; g++)
  begin : g_flt
    hcd_filter u_flt (
      .hclk               (hclk),
      .hresetn            (hresetn),
      .filter_enable      (s_q.fctl[HCD_FEN_BIT]),
      .sample_en          (sample_en),
      .filter_check_count (s_q.chk),
      .raw_in             (raw_sel[g]),
      .filt_out           (filt[g])
    );
  end

  // Decoder code is {A, B, C} with A in the high bit.
  assign hw_code = s_q.ctrl[HCD_DLY_BIT] ? s_q.dly_out
                                         : {filt[0], filt[1], filt[2]};
  assign code = s_q.ctrl[HCD_MODE_BIT] ? hw_code
                : {s_q.spos[0], s_q.spos[1], s_q.spos[2]};

  always_comb
  begin
    idx   = 3'h0;
    valid = 1'b1;
    if (!s_q.ctrl[HCD_ANG_BIT])
    begin
      unique case (code)
        3'b100:  idx = 3'h0;
        3'b110:  idx = 3'h1;
        3'b111:  idx = 3'h2;
        3'b011:  idx = 3'h3;
        3'b001:  idx = 3'h4;
        3'b000:  idx = 3'h5;
        default: valid = 1'b0;
      endcase
    end
    else
    begin
      unique case (code)
        3'b100:  idx = 3'h0;
        3'b110:  idx = 3'h1;
        3'b010:  idx = 3'h2;
        3'b011:  idx = 3'h3;
        3'b001:  idx = 3'h4;
        3'b101:  idx = 3'h5;
        default: valid = 1'b0;
      endcase
    end
  end

  // Edge detect on the filtered signals, ahead of any delay.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      unique case (s_q.srce[2*i +: 2])
        HCD_EDGE_OFF:  edge_hit[i] = 1'b0;
        HCD_EDGE_RISE: edge_hit[i] = filt[i] & ~s_q.prev[i];
        HCD_EDGE_FALL: edge_hit[i] = ~filt[i] & s_q.prev[i];
        HCD_EDGE_BOTH: edge_hit[i] = filt[i] ^ s_q.prev[i];
      endcase
    end
  end

  // One-hot of the chosen timer; select 11 names none, so a delay waits.
  always_comb
  begin
    unique case (s_q.ctrl[HCD_TSEL_LSB +: 2])
      2'h0:    tsel_hot = 3'b001;
      2'h1:    tsel_hot = 3'b010;
      2'h2:    tsel_hot = 3'b100;
      default: tsel_hot = 3'b000;
    endcase
  end

  assign a_phase = hsel && hready && htrans[1];

  always_comb
  begin
    s_d       = s_q;
    s_d.div   = s_q.div + 7'h01;
    s_d.prev  = filt;
    s_d.pulse = edge_hit;
    // Set wins over a clear arriving in the same cycle.
    s_d.stat  = s_q.stat | edge_hit;
    // Delay path: capture each new code, release it on the timer match.
    if (!s_q.ctrl[HCD_DLY_BIT])
    begin
      s_d.dly_in   = 3'h0;
      s_d.dly_out  = 3'h0;
      s_d.dly_pend = 1'b0;
    end
    else if ({filt[0], filt[1], filt[2]} != s_q.dly_in)
    begin
      s_d.dly_in   = {filt[0], filt[1], filt[2]};
      s_d.dly_pend = 1'b1;
    end
    else if (s_q.dly_pend && |(delay_timer_match & tsel_hot))
    begin
      s_d.dly_out  = s_q.dly_in;
      s_d.dly_pend = 1'b0;
    end
    // Data phase of a write.
    if (s_q.dph_wr)
    begin
      unique case (s_q.dph_addr)
        HCD_CTRL_ADDR: s_d.ctrl = hwdata[7:0];
        HCD_SRCE_ADDR: s_d.srce = hwdata[6:0];
        HCD_SPOS_ADDR: s_d.spos = hwdata[2:0];
        HCD_FCTL_ADDR: s_d.fctl = hwdata[3:0];
        HCD_CHK_ADDR:  s_d.chk  = hwdata[4:0];
        HCD_IEN_ADDR:  s_d.ien  = hwdata[2:0];
        HCD_ICLR_ADDR: s_d.stat = (s_q.stat & ~hwdata[2:0]) | edge_hit;
        default:
        begin
          for (int n = 0; n < HCD_TBL_N; n++)
            if (s_q.dph_addr == 8'(HCD_TBL_BASE + 8'(4 * n)))
              s_d.tbl[n] = hwdata[5:0];
        end
      endcase
    end
    // Address phase: latch writes, build read data now for a zero wait.
    s_d.dph_wr = a_phase && hwrite;
    s_d.dph_addr = haddr[7:0];
    if (a_phase && !hwrite)
    begin
      s_d.rdata = 32'h0;
      unique case (haddr[7:0])
        HCD_CTRL_ADDR: s_d.rdata[7:0] = s_q.ctrl;
        HCD_SRCE_ADDR: s_d.rdata[6:0] = s_q.srce;
        HCD_SPOS_ADDR: s_d.rdata[2:0] = s_q.spos;
        HCD_FCTL_ADDR: s_d.rdata[3:0] = s_q.fctl;
        HCD_CHK_ADDR:  s_d.rdata[4:0] = s_q.chk;
        HCD_STAT_ADDR: s_d.rdata[2:0] = s_q.stat;
        HCD_IEN_ADDR:  s_d.rdata[2:0] = s_q.ien;
        default:
        begin
          for (int n = 0; n < HCD_TBL_N; n++)
            if (haddr[7:0] == 8'(HCD_TBL_BASE + 8'(4 * n)))
              s_d.rdata[5:0] = s_q.tbl[n];
        end
      endcase
    end
    // Drive: brake first, then invalid code, then disable, then table.
    if (s_q.ctrl[HCD_BRK_BIT])
      s_d.drive = HCD_BRAKE_PAT;
    else if (!valid)
      s_d.drive = 6'h00;
    else if (!s_q.ctrl[HCD_EN_BIT])
      s_d.drive = 6'h00;
    else
      s_d.drive = s_q.tbl[({1'b0, idx}
                  + (s_q.ctrl[HCD_DIR_BIT] ? HCD_BWD_OFS : 4'h0))];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q      <= '0;
      s_q.ctrl <= HCD_CTRL_RST;
    end
    else
      s_q <= s_d;
  end

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = s_q.rdata;
  assign delay_timer_run = s_q.dly_pend ? tsel_hot : 3'b000;
  assign drive_a_top     = s_q.drive[5];
  assign drive_a_bottom  = s_q.drive[4];
  assign drive_b_top     = s_q.drive[3];
  assign drive_b_bottom  = s_q.drive[2];
  assign drive_c_top     = s_q.drive[1];
  assign drive_c_bottom  = s_q.drive[0];
  assign position_irq_a  = s_q.pulse[0];
  assign position_irq_b  = s_q.pulse[1];
  assign position_irq_c  = s_q.pulse[2];
  assign irq             = |(s_q.stat & s_q.ien);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_brake_pattern: assert property (s_q.ctrl[HCD_BRK_BIT]
    |=> s_q.drive == HCD_BRAKE_PAT)
    else $error("brake pattern not driven");
  a_disable_free: assert property
    (!s_q.ctrl[HCD_BRK_BIT] && !s_q.ctrl[HCD_EN_BIT]
    |=> s_q.drive == 6'h00)
    else $error("disabled decoder drives outputs");
  a_invalid_off: assert property (!s_q.ctrl[HCD_BRK_BIT] && !valid
    |=> s_q.drive == 6'h00)
    else $error("invalid code drives outputs");
  a_fwd_first: assert property (s_q.ctrl[2:0] == 3'b001
    && code == 3'b100 |=> s_q.drive == $past(s_q.tbl[0]))
    else $error("forward entry 0 not selected");
  a_bwd_last: assert property (s_q.ctrl[2:0] == 3'b011
    && code == 3'b101 && s_q.ctrl[HCD_ANG_BIT]
    |=> s_q.drive == $past(s_q.tbl[11]))
    else $error("backward entry 11 not selected");
  a_angle_third: assert property (s_q.ctrl[2:0] == 3'b001
    && s_q.ctrl[HCD_ANG_BIT] && code == 3'b010
    |=> s_q.drive == $past(s_q.tbl[2]))
    else $error("120 degree entry 2 not selected");
  a_soft_source: assert property (!s_q.ctrl[HCD_MODE_BIT]
    |-> code == {s_q.spos[0], s_q.spos[1], s_q.spos[2]})
    else $error("software position not used");
  a_rise_irq: assert property (s_q.srce[1:0] == HCD_EDGE_RISE
    && filt[0] && !s_q.prev[0] |=> s_q.stat[0] && position_irq_a)
    else $error("rising edge missed on channel A");
  a_fall_quiet: assert property (s_q.srce[1:0] == HCD_EDGE_FALL
    && filt[0] && !s_q.prev[0] |=> !position_irq_a)
    else $error("rising edge flagged in falling mode");
  a_spos_rdzero: assert property (a_phase && !hwrite
    && haddr[7:0] == HCD_SPOS_ADDR |=> hrdata[31:3] == 29'h0)
    else $error("unimplemented bits read nonzero");
  a_comp_source: assert property (s_q.srce[HCD_SRC_BIT]
    |-> raw_sel == comparator_outputs)
    else $error("comparator source not routed");
  // The unused select names no timer, so a pending code must stay put.
  a_unused_waits: assert property (s_q.ctrl[HCD_DLY_BIT]
    && s_q.ctrl[HCD_TSEL_LSB +: 2] == 2'h3 && s_q.dly_pend
    |=> s_q.dly_pend)
    else $error("unused timer select released a delay");
  a_filter_bypass: assert property (!s_q.fctl[HCD_FEN_BIT]
    |-> filt == raw_sel)
    else $error("disabled filter altered a position");
  a_sample_gap: assert property (sample_en |=> !sample_en)
    else $error("filter sampled on two cycles in a row");
  a_filter_hold: assert property (s_q.fctl[HCD_FEN_BIT] && !sample_en
    && !s_q.dph_wr |=> $stable(filt))
    else $error("filtered position moved between samples");

  c_brake: cover property (s_q.ctrl[HCD_BRK_BIT]
    ##1 s_q.drive == HCD_BRAKE_PAT);
  c_backward: cover property (s_q.ctrl[2:0] == 3'b011 && valid);
  c_delay_release: cover property (s_q.dly_pend ##1 !s_q.dly_pend);
  c_irq: cover property (irq);
  c_filter_pass: cover property (s_q.fctl[HCD_FEN_BIT] && sample_en
    && filt != raw_sel);
endmodule : hcd_decoder
`default_nettype wire

/* File: bench/hcd_hall_model.sv */
// Purpose: Hall sensors and comparators on the decoder's far side.
// Assumes: Codes are commanded as {A,B,C}, with A in the top bit.
// Notes:   Pins follow the command one edge late, as a real sensor lags.
`timescale 1ns/1ps
`default_nettype none
module hcd_hall_model
(
  // Clock
  input  wire logic       hclk,
  // Commanded rotor position
  input  wire logic [2:0] sens_code,
  input  wire logic [2:0] cmp_code,
  // Sensor side, bit 0 is phase A
  output var logic  [2:0] sensor_pins,
  output var logic  [2:0] comparator_outputs
);
  initial
  begin
    sensor_pins        = 3'h0;
    comparator_outputs = 3'h0;
  end
  always @(posedge hclk)
  begin
    sensor_pins        <= {sens_code[0], sens_code[1], sens_code[2]};
    comparator_outputs <= {cmp_code[0], cmp_code[1], cmp_code[2]};
  end
endmodule : hcd_hall_model
`default_nettype wire

/* File: bench/hcd_decoder_tb.sv */
// Purpose: Self-checking bench for the hall commutation decoder.
// Assumes: AHB-Lite slave; the master waits on hready, whatever the delay.
// Notes:   Filter timing is checked at two rates, between bounds not edges.
`timescale 1ns/1ps
`default_nettype none
module hcd_decoder_tb
  import hcd_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sens, cmp, tmatch, trun, pins, cmps, pirq;
  logic [5:0]  drv;
  logic        irq;
  logic [7:0]  tbl [12];
  int          num_errors, tests_run;
  localparam logic [2:0] ord60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  localparam logic [2:0] ord120 [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};

  always #12.5 hclk = ~hclk;

  hcd_hall_model hcd_hall_model_inst (.hclk(hclk), .sens_code(sens),
    .cmp_code(cmp), .sensor_pins(pins), .comparator_outputs(cmps));
  hcd_decoder hcd_decoder_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .sensor_pins(pins),
    .comparator_outputs(cmps), .delay_timer_match(tmatch),
    .delay_timer_run(trun), .drive_a_top(drv[5]), .drive_a_bottom(drv[4]),
    .drive_b_top(drv[3]), .drive_b_bottom(drv[2]), .drive_c_top(drv[1]),
    .drive_c_bottom(drv[0]), .position_irq_a(pirq[0]),
    .position_irq_b(pirq[1]), .position_irq_c(pirq[2]), .irq(irq));

  function automatic logic [5:0] exp_drv(logic [7:0] c, logic [2:0] p);
    int idx;
    idx = -1;
    for (int i = 0; i < 6; i++)
      if (p == (c[HCD_ANG_BIT] ? ord120[i] : ord60[i])) idx = i;
    if (c[HCD_BRK_BIT]) return HCD_BRAKE_PAT;
    if (!c[HCD_EN_BIT] || idx < 0) return 6'h00;
    return tbl[idx + (c[HCD_DIR_BIT] ? 6 : 0)][5:0];
  endfunction : exp_drv

  task check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Address phase held until hready, then data phase until hready again.
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h00, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick

  task report_and_stop;
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    logic [7:0] c;
    logic [2:0] p, r;
    hclk = 0; hresetn = 0; hsel = 1; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; tmatch = 0; sens = 0; cmp = 0;
    num_errors = 0; tests_run = 0;
    void'($urandom(18991));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    check("drv_rst", 32'(drv), 32'h0);
    ahb(0, HCD_CTRL_ADDR, 0);
    check("ctrl_rst", rd, {24'h0, HCD_CTRL_RST});
    for (int i = 0; i < 12; i++)
    begin
      // Entry 2 opposes entry 0, so a late filtered change stays visible.
      tbl[i] = (i == 2) ? ~tbl[0] : 8'($urandom);
      ahb(1, HCD_TBL_BASE + 8'(4 * i), {24'h0, tbl[i]});
    end
    for (int i = 0; i < 12; i++)
    begin
      ahb(0, HCD_TBL_BASE + 8'(4 * i), 0);
      check("tbl_rd", rd, {26'h0, tbl[i][5:0]});
    end
    ahb(1, HCD_SPOS_ADDR, 32'hff);
    ahb(0, HCD_SPOS_ADDR, 0);
    check("spos_rd", rd, 32'h7);
    ahb(1, HCD_SRCE_ADDR, 32'hff);
    ahb(0, HCD_SRCE_ADDR, 0);
    check("srce_rd", rd, 32'h7f);
    ahb(1, HCD_SRCE_ADDR, 0);
    // Every brake, direction, enable and angle mix against every code, codes in random order.
    for (int k = 0; k < 16; k++)
    begin
      c = {3'h0, k[3], 1'b0, k[2:0]};
      ahb(1, HCD_CTRL_ADDR, {24'h0, c});
      r = 3'($urandom);
      for (int j = 0; j < 8; j++)
      begin
        p = 3'(j) ^ r;
        ahb(1, HCD_SPOS_ADDR, {29'h0, p[0], p[1], p[2]});
        tick(2);
        check("drv_sw", 32'(drv), 32'(exp_drv(c, p)));
      end
    end
    // Hardware source: pins or comparators, filter bypassed.
    c = 8'h09;
    ahb(1, HCD_CTRL_ADDR, {24'h0, c});
    for (int t = 0; t < 8; t++)
    begin
      sens <= 3'($urandom);
      cmp  <= 3'($urandom);
      ahb(1, HCD_SRCE_ADDR, {25'h0, t[0], 6'h0});
      tick(3);
      check("drv_hw", 32'(drv), 32'(exp_drv(c, t[0] ? cmp : sens)));
    end
    ahb(1, HCD_SRCE_ADDR, 0);
    sens <= 3'h4;
    tick(3);
    check("drv_byp", 32'(drv), 32'(exp_drv(c, 3'h4)));
    // Delay path through each selectable timer.
    for (int s = 0; s < 4; s++)
    begin
      ahb(1, HCD_CTRL_ADDR, {2'(s), 6'h29});
      p = s[0] ? 3'h4 : 3'h6;
      sens <= p;
      tick(4);
      check("trun_on", 32'(trun), (s < 3) ? 32'h1 << s : 32'h0);
      tmatch <= (s < 3) ? 3'(1 << s) : 3'h7;
      tick(1);
      tmatch <= 3'h0;
      tick(3);
      check("drv_dly", 32'(drv), 32'(exp_drv(c, (s < 3) ? p : 3'h6)));
      check("trun_off", 32'(trun), 32'h0);
    end
    ahb(1, HCD_CTRL_ADDR, {24'h0, c});
    // Edge field of channel A at each of its four settings: a rise, then a fall.
    for (int m = 0; m < 4; m++)
    begin
      ahb(1, HCD_SRCE_ADDR, 32'(m));
      sens <= 3'h0;
      tick(3);
      ahb(1, HCD_ICLR_ADDR, 32'h7);
      sens <= 3'h4;
      tick(4);
      ahb(0, HCD_STAT_ADDR, 0);
      check("stat_rise", rd, 32'(m & 1));
      ahb(1, HCD_ICLR_ADDR, 32'h7);
      sens <= 3'h0;
      tick(4);
      ahb(0, HCD_STAT_ADDR, 0);
      check("stat_fall", rd, 32'(m >> 1));
    end
    // Both edges on all three channels; each pulse lasts one cycle.
    ahb(1, HCD_SRCE_ADDR, 32'h3f);
    sens <= 3'h7;
    tick(2);
    check("pirq_on", 32'(pirq), 32'h7);
    tick(1);
    check("pirq_off", 32'(pirq), 32'h0);
    ahb(0, HCD_STAT_ADDR, 0);
    check("stat_all", rd, 32'h7);
    ahb(1, HCD_IEN_ADDR, 32'h1);
    tick(1);
    check("irq_on", 32'(irq), 32'h1);
    ahb(1, HCD_ICLR_ADDR, 32'h1);
    tick(1);
    check("irq_clr", 32'(irq), 32'h0);
    // Filter on: a change waits out its agreeing samples at each rate.
    ahb(1, HCD_CHK_ADDR, 32'h3);
    ahb(1, HCD_FCTL_ADDR, 32'h8);
    sens <= 3'h4;
    tick(7);
    check("flt_hold2", 32'(drv), 32'(exp_drv(c, 3'h7)));
    tick(4);
    check("flt_pass2", 32'(drv), 32'(exp_drv(c, 3'h4)));
    ahb(1, HCD_CHK_ADDR, 32'h1);
    ahb(1, HCD_FCTL_ADDR, 32'ha);
    sens <= 3'h7;
    tick(10);
    check("flt_hold8", 32'(drv), 32'(exp_drv(c, 3'h4)));
    tick(9);
    check("flt_pass8", 32'(drv), 32'(exp_drv(c, 3'h7)));
    ahb(0, 8'hfc, 0);
    check("unmapped", rd, 32'h0);
    check("hresp", 32'(hresp), 32'h0);
    report_and_stop();
  end
endmodule : hcd_decoder_tb
`default_nettype wire
